/* hw/aesri_pkg.sv */
// Package: register map, field layout and types of the cipher register block
package aesri_pkg;

   localparam logic [8:0] OFF_LENGTH  = 9'h00c;
   localparam logic [8:0] OFF_IRQ_EN  = 9'h010;
   localparam logic [8:0] OFF_STATUS  = 9'h014;
   localparam logic [8:0] OFF_SPARE_A = 9'h018;
   localparam logic [8:0] OFF_SPARE_B = 9'h01c;
   localparam logic [8:0] OFF_CIPHER_KEY_WORD0    = 9'h020;
   localparam logic [8:0] OFF_CIPHER_KEY_WORD1    = 9'h024;
   localparam logic [8:0] OFF_KEY2    = 9'h028;
   localparam logic [8:0] OFF_KEY3    = 9'h02c;
   localparam logic [8:0] OFF_IV0     = 9'h030;
   localparam logic [8:0] OFF_IV1     = 9'h034;
   localparam logic [8:0] OFF_IV2     = 9'h038;
   localparam logic [8:0] OFF_IV3     = 9'h03c;
   localparam logic [8:0] OFF_RES0    = 9'h050;
   localparam logic [8:0] OFF_RES1    = 9'h054;
   localparam logic [8:0] OFF_RES2    = 9'h058;
   localparam logic [8:0] OFF_RES3    = 9'h05c;
   localparam logic [8:0] OFF_CLEAR   = 9'h060;
   localparam logic [8:0] OFF_MEM_LO  = 9'h100;
   localparam logic [8:0] OFF_MEM_HI  = 9'h1fc;

   localparam int          NUM_EVT   = 4;
   localparam int          EVT_ENC   = 0;
   localparam int          EVT_AFAIL = 1;
   localparam int          EVT_DECOK = 2;
   localparam int          EVT_SGL   = 3;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [3:0]  EVT_ZERO  = 4'h0;
   localparam logic [7:0]  LEN_ZERO  = 8'h00;
   localparam int          MEM_AW    = 6;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;

   typedef struct packed {
      logic [7:0] payload_len;
      logic [7:0] aad_len;
   } aesri_len_t;

   typedef struct packed {
      logic          wr;
      logic [MEM_AW-1:0] addr;
      logic [31:0]   data;
   } aesri_mem_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b01,
      ST_WRITE = 2'b10
   } aesri_state_t;

endpackage : aesri_pkg

/* hw/aesri_mem.sv */
// Packet memory behind the bus window, registered read port
`timescale 1ns/1ps
module aesri_mem #(
   parameter int AW = 6
) (
   input  wire logic          hclk,
   input  wire aesri_pkg::aesri_mem_t wr_port,
   input  wire logic [AW-1:0] rd_addr,
   output logic [31:0]        rd_data
);

   logic [31:0] mem [2**AW];

   always_ff @(posedge hclk)
   begin
      if (wr_port.wr)
      begin
         mem[wr_port.addr] <= wr_port.data;
      end
      rd_data <= mem[rd_addr];
   end

endmodule : aesri_mem

/* hw/aesri_regs.sv */
// Cipher engine register block: AHB-Lite slave, key, nonce, results, events
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Status bits 0..3 hold four events, rest zero
// - Key built from four words, low word first
// - Words 0x30..0x3C: input block or nonce
// - Result words 0x50..0x5C read-only, reset zero
// - Writes 0x100..0x1FC go into packet memory
// - Offsets 0x18, 0x1C reserved, read zero
// - Four enable bits gate events, reset cleared
module aesri_regs #(
   parameter int MEM_AW = aesri_pkg::MEM_AW
) (
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic [31:0]               hrdata,
   output logic                      hreadyout,
   output logic                      hresp,
   output logic [127:0]              cipher_key,
   output logic [127:0]              iv_or_input,
   output aesri_pkg::aesri_len_t     length_cfg,
   input  wire logic                 result_valid,
   input  wire logic [127:0]         result_block,
   input  wire logic [3:0]           event_pulse,
   input  wire logic [MEM_AW-1:0]    eng_mem_addr,
   output logic [31:0]               eng_mem_data,
   output logic                      irq
);

   //////////////////////////////////////////////////////////////////////////
   // Address phase capture
   aesri_pkg::aesri_state_t state_ff;
   aesri_pkg::aesri_state_t nxt_state;
   logic [8:0]              addr_ff;
   logic [8:0]              nxt_addr;
   logic                    rd_ff;
   logic                    nxt_rd;
   logic                    take;

   assign take = hsel && hready && (htrans == aesri_pkg::HTRANS_NONSEQ);

   always_comb
   begin
      nxt_state = aesri_pkg::ST_IDLE;
      nxt_addr  = addr_ff;
      nxt_rd    = 1'b0;
      if (take)
      begin
         nxt_addr = haddr[8:0];
         nxt_rd   = !hwrite;
         if (hwrite)
         begin
            nxt_state = aesri_pkg::ST_WRITE;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_ff <= aesri_pkg::ST_IDLE;
         addr_ff  <= 9'h000;
         rd_ff    <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         addr_ff  <= nxt_addr;
         rd_ff    <= nxt_rd;
      end
   end

   logic wr_en;
   assign wr_en     = (state_ff == aesri_pkg::ST_WRITE);
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   //////////////////////////////////////////////////////////////////////////
   // Writable registers
   logic [31:0]          key_ff [4];
   logic [31:0]          nxt_key [4];
   logic [31:0]          iv_ff [4];
   logic [31:0]          nxt_iv [4];
   logic [3:0]           en_ff;
   logic [3:0]           nxt_en;
   aesri_pkg::aesri_len_t len_ff;
   aesri_pkg::aesri_len_t nxt_len;

   always_comb
   begin
      nxt_en  = en_ff;
      nxt_len = len_ff;
      for (int i = 0; i < 4; i++)
      begin
         nxt_key[i] = key_ff[i];
         nxt_iv[i]  = iv_ff[i];
      end
      if (wr_en)
      begin
         for (int i = 0; i < 4; i++)
         begin
            if (addr_ff == aesri_pkg::OFF_CIPHER_KEY_WORD0 + 9'(4 * i))
            begin
               nxt_key[i] = hwdata;
            end
            if (addr_ff == aesri_pkg::OFF_IV0 + 9'(4 * i))
            begin
               nxt_iv[i] = hwdata;
            end
         end
         if (addr_ff == aesri_pkg::OFF_IRQ_EN)
         begin
            nxt_en = hwdata[aesri_pkg::NUM_EVT-1:0];
         end
         if (addr_ff == aesri_pkg::OFF_LENGTH)
         begin
            nxt_len = hwdata[$bits(aesri_pkg::aesri_len_t)-1:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int i = 0; i < 4; i++)
         begin
            key_ff[i] <= aesri_pkg::WORD_ZERO;
            iv_ff[i]  <= aesri_pkg::WORD_ZERO;
         end
         en_ff  <= aesri_pkg::EVT_ZERO;
         len_ff <= {aesri_pkg::LEN_ZERO, aesri_pkg::LEN_ZERO};
      end
      else
      begin
         key_ff <= nxt_key;
         iv_ff  <= nxt_iv;
         en_ff  <= nxt_en;
         len_ff <= nxt_len;
      end
   end

   assign cipher_key  = {key_ff[3], key_ff[2], key_ff[1], key_ff[0]};
   assign iv_or_input = {iv_ff[3], iv_ff[2], iv_ff[1], iv_ff[0]};
   assign length_cfg  = len_ff;

   //////////////////////////////////////////////////////////////////////////
   // Results and sticky events
   logic [127:0] res_ff;
   logic [127:0] nxt_res;
   logic [3:0]   sts_ff;
   logic [3:0]   nxt_sts;
   logic [3:0]   clr;

   always_comb
   begin
      clr = aesri_pkg::EVT_ZERO;
      if (wr_en && addr_ff == aesri_pkg::OFF_CLEAR)
      begin
         clr = hwdata[aesri_pkg::NUM_EVT-1:0];
      end
      nxt_sts = (sts_ff & ~clr) | event_pulse;
      nxt_res = result_valid ? result_block : res_ff;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         res_ff <= {4{aesri_pkg::WORD_ZERO}};
         sts_ff <= aesri_pkg::EVT_ZERO;
      end
      else
      begin
         res_ff <= nxt_res;
         sts_ff <= nxt_sts;
      end
   end

   assign irq = |(sts_ff & en_ff);

   //////////////////////////////////////////////////////////////////////////
   // Packet memory window
   aesri_pkg::aesri_mem_t mem_wr;
   logic                  in_window;
   logic [31:0]           mem_rd;

   assign in_window = (addr_ff >= aesri_pkg::OFF_MEM_LO)
                   && (addr_ff <= aesri_pkg::OFF_MEM_HI);

   always_comb
   begin
      mem_wr.wr   = wr_en && in_window;
      mem_wr.addr = addr_ff[MEM_AW+1:2];
      mem_wr.data = hwdata;
   end

   aesri_mem #(
      .AW(MEM_AW)
   ) u_mem (
      .hclk    (hclk),
      .wr_port (mem_wr),
      .rd_addr (eng_mem_addr),
      .rd_data (mem_rd)
   );

   assign eng_mem_data = mem_rd;

   //////////////////////////////////////////////////////////////////////////
   // Read data, registered at the data phase start
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;

   always_comb
   begin
      nxt_rdata = aesri_pkg::WORD_ZERO;
      if (take && !hwrite)
      begin
         unique case (haddr[8:0])
            aesri_pkg::OFF_LENGTH:  nxt_rdata = 32'(len_ff);
            aesri_pkg::OFF_IRQ_EN:  nxt_rdata = 32'(en_ff);
            aesri_pkg::OFF_STATUS:  nxt_rdata = 32'(sts_ff);
            aesri_pkg::OFF_CIPHER_KEY_WORD0:    nxt_rdata = key_ff[0];
            aesri_pkg::OFF_CIPHER_KEY_WORD1:    nxt_rdata = key_ff[1];
            aesri_pkg::OFF_KEY2:    nxt_rdata = key_ff[2];
            aesri_pkg::OFF_KEY3:    nxt_rdata = key_ff[3];
            aesri_pkg::OFF_IV0:     nxt_rdata = iv_ff[0];
            aesri_pkg::OFF_IV1:     nxt_rdata = iv_ff[1];
            aesri_pkg::OFF_IV2:     nxt_rdata = iv_ff[2];
            aesri_pkg::OFF_IV3:     nxt_rdata = iv_ff[3];
            aesri_pkg::OFF_RES0:    nxt_rdata = res_ff[31:0];
            aesri_pkg::OFF_RES1:    nxt_rdata = res_ff[63:32];
            aesri_pkg::OFF_RES2:    nxt_rdata = res_ff[95:64];
            aesri_pkg::OFF_RES3:    nxt_rdata = res_ff[127:96];
            default:                nxt_rdata = aesri_pkg::WORD_ZERO;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rdata_ff <= aesri_pkg::WORD_ZERO;
      end
      else
      begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign hrdata = rd_ff ? rdata_ff : aesri_pkg::WORD_ZERO;

endmodule : aesri_regs

/* bench/aesri_regs_sva.sv */
// Bus-side assertions for the cipher register block
`timescale 1ns/1ps
module aesri_regs_sva (
   input wire logic         hclk,
   input wire logic         hresetn,
   input wire logic         hsel,
   input wire logic [31:0]  haddr,
   input wire logic [1:0]   htrans,
   input wire logic         hwrite,
   input wire logic [31:0]  hwdata,
   input wire logic [31:0]  hrdata,
   input wire logic [127:0] cipher_key,
   input wire logic [127:0] iv_or_input,
   input wire logic [3:0]   event_pulse,
   input wire logic         irq
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic [8:0] pa_ff;
   logic       pw_ff;
   logic       pr_ff;
   wire        tk = hsel && htrans == aesri_pkg::HTRANS_NONSEQ;
   // Data-phase tracker
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         {pa_ff, pw_ff, pr_ff} <= '0;
      else
         {pa_ff, pw_ff, pr_ff} <= {haddr[8:0], tk && hwrite, tk && !hwrite};
   a_status_upper: assert property (pr_ff && pa_ff == 9'h014
      |-> hrdata[31:4] == 28'h0) else $error("status upper bits set");
   a_spare_zero: assert property (pr_ff && pa_ff[8:3] == 6'h03
      |-> hrdata == 32'h0) else $error("spare word not zero");
   a_cipher_key_word0_write: assert property (pw_ff && pa_ff == 9'h020
      |=> cipher_key[31:0] == $past(hwdata)) else $error("key word 0");
   a_cipher_key_word1_write: assert property (pw_ff && pa_ff == 9'h024
      |=> cipher_key[63:32] == $past(hwdata)) else $error("key word 1");
   a_iv3_write: assert property (pw_ff && pa_ff == 9'h03c
      |=> iv_or_input[127:96] == $past(hwdata)) else $error("iv word 3");
   a_key_hold: assert property (!pw_ff |=> $stable(cipher_key))
      else $error("key changed without write");
   a_irq_cause: assert property ($rose(irq)
      |-> $past(|event_pulse) || $past(pw_ff)) else $error("irq rise");
   a_irq_sticky: assert property ($fell(irq) |-> $past(pw_ff))
      else $error("irq fell without write");
endmodule : aesri_regs_sva
bind aesri_regs aesri_regs_sva aesri_regs_sva_inst (.hclk, .hresetn,
   .hsel, .haddr, .htrans, .hwrite, .hwdata, .hrdata, .cipher_key,
   .iv_or_input, .event_pulse, .irq);

/* bench/aesri_eng_model.sv */
// Engine-side model: event pulses and single-block results
`timescale 1ns/1ps
module aesri_eng_model (
   input  wire logic    hclk,
   output logic [3:0]   event_pulse,
   output logic         result_valid,
   output logic [127:0] result_block
);
   initial
   begin
      event_pulse = 4'h0;
      result_valid = 1'b0;
      result_block = '1;
   end
   // One-cycle pulse, block inverted once released
   task automatic fire(logic [3:0] e, logic [127:0] b, logic v);
      event_pulse <= e;
      result_valid <= v;
      result_block <= b;
      @(posedge hclk);
      event_pulse <= 4'h0;
      result_valid <= 1'b0;
      result_block <= ~b;
   endtask : fire
endmodule : aesri_eng_model

/* bench/testbench.sv */
// Self-checking bench for the cipher register block
`timescale 1ns/1ps
module testbench;
   logic                  hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic                  rv, irq;
   logic [31:0]           haddr, hwdata, hrdata, md, d;
   logic [1:0]            htrans;
   logic [2:0]            hsize;
   logic [5:0]            ma;
   logic [3:0]            ev, e, o;
   logic [127:0]          ck, iv, rb, kx, ix, blk;
   aesri_pkg::aesri_len_t lc;
   int                    fail_count = 0;
   int                    checks = 0;
   aesri_regs aesri_regs_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
      .hresp, .cipher_key(ck), .iv_or_input(iv), .length_cfg(lc),
      .result_valid(rv), .result_block(rb), .event_pulse(ev),
      .eng_mem_addr(ma), .eng_mem_data(md), .irq);
   aesri_eng_model aesri_eng_model_inst (.hclk, .event_pulse(ev),
      .result_valid(rv), .result_block(rb));
   task automatic chk(string n, logic [127:0] x, logic [127:0] s);
      checks++;
      if (s !== x)
      begin
         $display("wrong value %s exp %h seen %h", n, x, s);
         fail_count++;
      end
   endtask : chk
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   task automatic hs();
      int n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 40);
      if (hreadyout !== 1'b1)
      begin
         fail_count++;
         summarize();
      end
   endtask : hs
   // Single word transfer; reads compare in the data phase
   task automatic xfer(logic w, logic [8:0] a, logic [31:0] wd,
                       logic [31:0] x);
      haddr <= {23'h0, a};
      hwrite <= w;
      hsel <= 1'b1;
      htrans <= aesri_pkg::HTRANS_NONSEQ;
      hs();
      htrans <= 2'h0;
      hwdata <= wd;
      hs();
      chk("hresp", 1'b0, hresp);
      if (!w)
         chk($sformatf("rd %h", a), x, hrdata);
   endtask : xfer
   task automatic ckirq(logic x);
      @(negedge hclk);
      chk("irq", x, irq);
      @(posedge hclk);
   endtask : ckirq
   function automatic logic [3:0] other_evt(logic [3:0] v);
      return {v[2:0], v[3]};
   endfunction : other_evt
   initial
   begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   initial
   begin
      {hresetn, hsel, haddr, htrans, hwrite, hwdata, ma} = '0;
      hsize = aesri_pkg::HSIZE_WORD;
      void'($urandom(32'hb403));
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      for (int a = 0; a < 'h68; a += 4)
         xfer(1'b0, a[8:0], 0, 0);
      $display("test reset values done");
      d = $urandom;
      xfer(1'b1, 9'h00c, d, 0);
      xfer(1'b0, 9'h00c, 0, {16'h0, d[15:0]});
      for (int i = 0; i < 4; i++)
      begin
         kx[i*32 +: 32] = $urandom;
         ix[i*32 +: 32] = $urandom;
         xfer(1'b1, 9'h020 + 9'(4*i), kx[i*32 +: 32], 0);
         xfer(1'b1, 9'h030 + 9'(4*i), ix[i*32 +: 32], 0);
      end
      @(negedge hclk);
      chk("key", kx, ck);
      chk("iv", ix, iv);
      chk("len", d[15:0], lc);
      @(posedge hclk);
      xfer(1'b0, 9'h024, 0, kx[63:32]);
      xfer(1'b1, 9'h018, $urandom, 0);
      xfer(1'b1, 9'h050, $urandom, 0);
      xfer(1'b0, 9'h018, 0, 0);
      xfer(1'b0, 9'h050, 0, 0);
      $display("test key and nonce done");
      blk = {$urandom, $urandom, $urandom, $urandom};
      aesri_eng_model_inst.fire(4'h0, blk, 1'b1);
      for (int i = 0; i < 4; i++)
         xfer(1'b0, 9'h050 + 9'(4*i), 0, blk[i*32 +: 32]);
      $display("test result words done");
      for (int b = 0; b < 4; b++)
      begin
         e = 4'h1 << b;
         o = other_evt(e);
         xfer(1'b1, 9'h010, {28'h0, e}, 0);
         xfer(1'b0, 9'h010, 0, {28'h0, e});
         aesri_eng_model_inst.fire(o, blk, 1'b0);
         ckirq(1'b0);
         aesri_eng_model_inst.fire(e, blk, 1'b0);
         ckirq(1'b1);
         xfer(1'b0, 9'h014, 0, {28'h0, e | o});
         xfer(1'b1, 9'h060, {28'h0, e}, 0);
         ckirq(1'b0);
         xfer(1'b0, 9'h014, 0, {28'h0, o});
         xfer(1'b1, 9'h060, {28'h0, o}, 0);
      end
      $display("test events done");
      // Event pulse lands in the clear's data phase: set wins
      e = 4'h5;
      fork
         xfer(1'b1, 9'h060, {28'h0, e}, 0);
         begin
            @(posedge hclk);
            aesri_eng_model_inst.fire(e, blk, 1'b0);
         end
      join
      xfer(1'b0, 9'h014, 0, {28'h0, e});
      xfer(1'b1, 9'h060, {28'h0, e}, 0);
      xfer(1'b0, 9'h014, 0, 32'h0);
      $display("test set over clear done");
      for (int k = 0; k < 64; k += 63)
      begin
         d = $urandom;
         xfer(1'b1, 9'h100 + 9'(4*k), d, 0);
         ma <= k[5:0];
         @(posedge hclk);
         @(negedge hclk);
         chk("mem", d, md);
         @(posedge hclk);
      end
      $display("test packet memory done");
      summarize();
   end
endmodule : testbench
